/* core_model.sv */
// core and debug link model: turns bench requests into request pulses
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input wire logic fire_i,
	input wire logic [1:0] kind_i,
	output logic stop_o,
	output logic bg_o,
	output logic acc_o
);
	// a request lasts exactly as long as the bench holds fire, one cycle
	assign stop_o = fire_i && kind_i == 2'd0;
	assign bg_o = fire_i && kind_i == 2'd1;
	assign acc_o = fire_i && kind_i == 2'd2;
endmodule : core_model
`default_nettype wire

/* stop_ctrl_pkg.sv */
// package: register map, field positions and types for the stop mode controller
package stop_ctrl_pkg;
	// register byte offsets (32-bit words)
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] CLKGEN_OFS = 8'h08;
	// control register fields
	localparam int CTRL_STOP_ENABLE_BIT = 0;
	localparam int CTRL_DEEP_REQ_BIT = 1;
	localparam int CTRL_LVD_ENABLE_BIT = 2;
	localparam int CTRL_LOWVOLT_STOP_BIT = 3;
	localparam int CTRL_RTC_ENABLE_BIT = 4;
	localparam int CTRL_ADC_ASYNC_BIT = 5;
	localparam int CTRL_IRQ_WAKE_BIT = 6;
	localparam int CTRL_ACK_BIT = 7;
	// clock generator register fields
	localparam int CLK_INT_REF_EN_BIT = 0;
	localparam int CLK_INT_REF_STOP_BIT = 1;
	localparam int CLK_EXT_REF_EN_BIT = 2;
	localparam int CLK_EXT_REF_STOP_BIT = 3;
	localparam int CLK_HIGH_RANGE_BIT = 4;
	// reset values
	localparam logic [6:0] CTRL_RESET = 7'h00;
	localparam logic [4:0] CLKGEN_RESET = 5'h00;

	// operating mode of the controller
	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_LIGHT_STOP,
		MODE_DEEP_STOP,
		MODE_BACKGROUND
	} power_mode_t;

	// per-module keep-alive / standby controls
	typedef struct packed {
		logic debug_clk_on;
		logic regulator_full;
		logic periph_clk_on;
		logic core_clk_on;
		logic adc_on;
		logic clockgen_on;
		logic crystal_oscillator_on;
		logic rtc_on;
		logic acmp_on;
		logic core_power_on;
	} power_ctl_t;
endpackage : stop_ctrl_pkg

/* stop_mode_power_control.sv */
// module: stop mode sequencer with deep stop pin latching and debug hold
`timescale 1ns/1ps
`default_nettype none

module stop_mode_power_control #(
	parameter int PIN_COUNT = 8,
	parameter bit OLD_SILICON = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// classic wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// core side
	input wire logic stop_exec_i,
	input wire logic debug_mode_enable_i,
	input wire logic debug_background_cmd_i,
	input wire logic debug_status_access_i,
	output logic debug_status_error_o,
	output logic debug_status_grant_o,
	output logic debug_all_cmds_o,
	// asynchronous wake sources
	input wire logic reset_pin_n_i,
	input wire logic rtc_event_i,
	input wire logic shared_interrupt_pin_n_i,
	// pin control path
	input wire logic [PIN_COUNT-1:0] port_out_i,
	input wire logic [PIN_COUNT-1:0] port_dir_i,
	input wire logic [PIN_COUNT-1:0] periph_en_i,
	input wire logic [PIN_COUNT-1:0] periph_out_i,
	input wire logic [PIN_COUNT-1:0] periph_dir_i,
	output logic [PIN_COUNT-1:0] pin_out_o,
	output logic [PIN_COUNT-1:0] pin_oe_o,
	// power controls and resets
	output stop_ctrl_pkg::power_ctl_t power_ctl_o,
	output logic por_reset_o,
	output logic [1:0] mode_o
);
	stop_ctrl_pkg::power_mode_t mode_q;
	logic [6:0] ctrl_q;
	logic [4:0] clkgen_q;
	logic wake_flag_q;
	logic latched_q;
	logic por_q;
	logic [2:0] rst_sync_q;
	logic [2:0] rtc_sync_q;
	logic [2:0] irq_sync_q;
	logic [PIN_COUNT-1:0] hold_out_q;
	logic [PIN_COUNT-1:0] hold_oe_q;
	logic bus_req;
	logic ack_write;
	logic stop_en;
	logic deep_req;
	logic lvd_en;
	logic lvd_stop;
	logic rtc_en;
	logic reset_pin_low;
	logic rtc_seen;
	logic irq_low;
	logic deep_wake;
	logic stop_taken;
	logic deep_entry;
	logic [PIN_COUNT-1:0] live_out;
	logic [PIN_COUNT-1:0] live_oe;

	assign stop_en = ctrl_q[stop_ctrl_pkg::CTRL_STOP_ENABLE_BIT];
	assign deep_req = ctrl_q[stop_ctrl_pkg::CTRL_DEEP_REQ_BIT];
	assign lvd_en = ctrl_q[stop_ctrl_pkg::CTRL_LVD_ENABLE_BIT];
	assign lvd_stop = ctrl_q[stop_ctrl_pkg::CTRL_LOWVOLT_STOP_BIT];
	assign rtc_en = ctrl_q[stop_ctrl_pkg::CTRL_RTC_ENABLE_BIT];
	assign bus_req = cyc_i && stb_i && !ack_o;
	assign ack_write = bus_req && we_i && sel_i[0] && adr_i == stop_ctrl_pkg::CTRL_OFS
		&& dat_i[stop_ctrl_pkg::CTRL_ACK_BIT];

	// one decode of deep entry, shared by the mode and latch logic so they never disagree
	assign stop_taken = mode_q == stop_ctrl_pkg::MODE_RUN && stop_exec_i && stop_en;
	assign deep_entry = stop_taken && deep_req && !debug_mode_enable_i
		&& !(lvd_en && lvd_stop);

	// three-stage synchronisers; a change counts when stages two and three agree
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rst_sync_q <= 3'h7;
			rtc_sync_q <= 3'h0;
			irq_sync_q <= 3'h7;
		end
		else
		begin
			rst_sync_q <= {rst_sync_q[1:0], reset_pin_n_i};
			rtc_sync_q <= {rtc_sync_q[1:0], rtc_event_i};
			irq_sync_q <= {irq_sync_q[1:0], shared_interrupt_pin_n_i};
		end
	end
	assign reset_pin_low = !rst_sync_q[1] && !rst_sync_q[2];
	assign rtc_seen = rtc_sync_q[1] && rtc_sync_q[2];
	assign irq_low = !irq_sync_q[1] && !irq_sync_q[2];

	// deep stop exit sources; the interrupt pin only counts on older silicon
	assign deep_wake = reset_pin_low
		|| (rtc_en && rtc_seen)
		|| (OLD_SILICON && ctrl_q[stop_ctrl_pkg::CTRL_IRQ_WAKE_BIT] && irq_low);

	// mode sequencing
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mode_q <= stop_ctrl_pkg::MODE_RUN;
		else
		begin
			case (mode_q)
				stop_ctrl_pkg::MODE_RUN:
					if (stop_exec_i && stop_en)
					begin
						// debug or low-voltage stop enable forces the light mode
						if (deep_entry)
							mode_q <= stop_ctrl_pkg::MODE_DEEP_STOP;
						else
							mode_q <= stop_ctrl_pkg::MODE_LIGHT_STOP;
					end
				stop_ctrl_pkg::MODE_LIGHT_STOP:
					if (debug_mode_enable_i && debug_background_cmd_i)
						mode_q <= stop_ctrl_pkg::MODE_BACKGROUND;
					else if (reset_pin_low || (rtc_en && rtc_seen))
						mode_q <= stop_ctrl_pkg::MODE_RUN;
				stop_ctrl_pkg::MODE_DEEP_STOP:
					if (deep_wake)
						mode_q <= stop_ctrl_pkg::MODE_RUN;
				stop_ctrl_pkg::MODE_BACKGROUND:
					if (!debug_mode_enable_i)
						mode_q <= stop_ctrl_pkg::MODE_RUN;
				default:
					mode_q <= stop_ctrl_pkg::MODE_RUN;
			endcase
		end
	end

	// power-on style reset pulse on deep stop wake, clearing module registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			por_q <= 1'b0;
		else
			por_q <= mode_q == stop_ctrl_pkg::MODE_DEEP_STOP && deep_wake;
	end

	// wake flag: set on deep stop wake, cleared by acknowledge; set wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wake_flag_q <= 1'b0;
		else if (mode_q == stop_ctrl_pkg::MODE_DEEP_STOP && deep_wake)
			wake_flag_q <= 1'b1;
		else if (ack_write)
			wake_flag_q <= 1'b0;
	end

	// pin latches close on deep stop entry and open only on acknowledge
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			latched_q <= 1'b0;
		else if (mode_q != stop_ctrl_pkg::MODE_DEEP_STOP
			&& mode_q != stop_ctrl_pkg::MODE_RUN)
			latched_q <= latched_q;
		else if (deep_entry)
			latched_q <= 1'b1;
		else if (ack_write && mode_q == stop_ctrl_pkg::MODE_RUN)
			latched_q <= 1'b0;
	end

	// capture the pin drive at deep stop entry
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			hold_out_q <= '0;
			hold_oe_q <= '0;
		end
		else if (!latched_q)
		begin
			hold_out_q <= live_out;
			hold_oe_q <= live_oe;
		end
	end

	// pins follow an enabled peripheral, else the port registers as they stand
	always_comb
	begin
		for (int i = 0; i < PIN_COUNT; i++)
		begin
			live_out[i] = periph_en_i[i] ? periph_out_i[i] : port_out_i[i];
			live_oe[i] = periph_en_i[i] ? periph_dir_i[i] : port_dir_i[i];
		end
	end

	// registered pin drivers; latched copy wins while closed
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_out_o <= '0;
			pin_oe_o <= '0;
		end
		else if (latched_q)
		begin
			pin_out_o <= hold_out_q;
			pin_oe_o <= hold_oe_q;
		end
		else
		begin
			pin_out_o <= live_out;
			pin_oe_o <= live_oe;
		end
	end

	// per-module power and clock decisions for the current mode, registered one cycle late
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			power_ctl_o <= '1;
		else
		begin
			case (mode_q)
				stop_ctrl_pkg::MODE_LIGHT_STOP:
				begin
					power_ctl_o.debug_clk_on <= debug_mode_enable_i;
					power_ctl_o.regulator_full <= debug_mode_enable_i || (lvd_en && lvd_stop);
					power_ctl_o.periph_clk_on <= 1'b0;
					power_ctl_o.core_clk_on <= 1'b0;
					power_ctl_o.adc_on <= ctrl_q[stop_ctrl_pkg::CTRL_ADC_ASYNC_BIT]
						&& lvd_en && lvd_stop;
					power_ctl_o.clockgen_on <= clkgen_q[stop_ctrl_pkg::CLK_INT_REF_EN_BIT]
						&& clkgen_q[stop_ctrl_pkg::CLK_INT_REF_STOP_BIT];
					power_ctl_o.crystal_oscillator_on <= clkgen_q[stop_ctrl_pkg::CLK_EXT_REF_EN_BIT]
						&& clkgen_q[stop_ctrl_pkg::CLK_EXT_REF_STOP_BIT]
						&& (!clkgen_q[stop_ctrl_pkg::CLK_HIGH_RANGE_BIT]
						|| (lvd_en && lvd_stop));
					power_ctl_o.rtc_on <= rtc_en;
					power_ctl_o.acmp_on <= 1'b0;
					power_ctl_o.core_power_on <= 1'b1;
				end
				stop_ctrl_pkg::MODE_DEEP_STOP:
				begin
					// only RAM retention and the optional counter remain
					power_ctl_o <= '0;
					power_ctl_o.rtc_on <= rtc_en;
				end
				default:
					power_ctl_o <= '1;
			endcase
		end
	end

	// debug command gating: status accesses refused in light stop, neither granted nor refused in deep stop
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			debug_status_error_o <= 1'b0;
			debug_status_grant_o <= 1'b0;
		end
		else
		begin
			debug_status_error_o <= debug_status_access_i
				&& mode_q == stop_ctrl_pkg::MODE_LIGHT_STOP;
			debug_status_grant_o <= debug_status_access_i
				&& mode_q != stop_ctrl_pkg::MODE_LIGHT_STOP
				&& mode_q != stop_ctrl_pkg::MODE_DEEP_STOP;
		end
	end

	// background mode opens every debug command, not only the non-intrusive ones
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			debug_all_cmds_o <= 1'b0;
		else
			debug_all_cmds_o <= mode_q == stop_ctrl_pkg::MODE_BACKGROUND;
	end

	// control register; the acknowledge bit acts on the write and is never stored
	always_ff @(posedge clk_i)
	begin
		if (rst_i || por_q)
			ctrl_q <= stop_ctrl_pkg::CTRL_RESET;
		else if (bus_req && we_i && sel_i[0] && adr_i == stop_ctrl_pkg::CTRL_OFS)
			ctrl_q <= dat_i[6:0];
	end

	// clock generator stop controls; deep stop wake clears them like power-on
	always_ff @(posedge clk_i)
	begin
		if (rst_i || por_q)
			clkgen_q <= stop_ctrl_pkg::CLKGEN_RESET;
		else if (bus_req && we_i && sel_i[0] && adr_i == stop_ctrl_pkg::CLKGEN_OFS)
			clkgen_q <= dat_i[4:0];
	end

	// ack one cycle after the request is taken; gating on ack stops a double answer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= bus_req;
	end

	// read data follows the address every cycle, so it stands with ack; unmapped reads zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_o <= '0;
		else
		begin
			case (adr_i)
				stop_ctrl_pkg::CTRL_OFS: dat_o <= {25'h0, ctrl_q};
				stop_ctrl_pkg::STATUS_OFS: dat_o <= {28'h0, latched_q, wake_flag_q, mode_q};
				stop_ctrl_pkg::CLKGEN_OFS: dat_o <= {27'h0, clkgen_q};
				default: dat_o <= '0;
			endcase
		end
	end

	// power-on style reset pulse, one cycle, straight from a flop
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			por_reset_o <= 1'b0;
		else
			por_reset_o <= por_q;
	end

	// mode seen outside; it lags the sequencer by one cycle, like the power controls
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mode_o <= 2'h0;
		else
			mode_o <= mode_q;
	end
endmodule : stop_mode_power_control

`default_nettype wire

/* stop_mode_power_control_chk.sv */
// port assertions for the stop mode power controller
`timescale 1ns/1ps
`default_nettype none
module stop_mode_power_control_chk #(
	parameter int PIN_COUNT = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic debug_mode_enable_i,
	input wire logic debug_status_access_i,
	input wire logic debug_status_error_o,
	input wire logic debug_all_cmds_o,
	input wire logic [PIN_COUNT-1:0] pin_out_o,
	input wire logic [PIN_COUNT-1:0] pin_oe_o,
	input wire stop_ctrl_pkg::power_ctl_t power_ctl_o,
	input wire logic por_reset_o,
	input wire logic [1:0] mode_o
);
	// one clock domain; a reset voids every check
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// mode decodes; checks wait one cycle in a mode so lagging outputs settle
	logic lite;
	logic deep;
	assign lite = mode_o == 2'd1;
	assign deep = mode_o == 2'd2;
	ack_once_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
	ack_due_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not acked");
	clk_halt_a: assert property ((lite || deep) && $stable(mode_o) |->
		!power_ctl_o.periph_clk_on) else $error("peripheral clock in stop");
	deep_off_a: assert property (deep && $stable(mode_o) |->
		!(power_ctl_o.core_power_on || power_ctl_o.regulator_full))
		else $error("deep stop still powered");
	light_core_a: assert property (lite && $stable(mode_o) |->
		!power_ctl_o.acmp_on && !power_ctl_o.core_clk_on) else $error("light stop core on");
	debug_keep_a: assert property (lite && $stable(mode_o) && $past(debug_mode_enable_i) |->
		power_ctl_o.debug_clk_on && power_ctl_o.regulator_full)
		else $error("debug clock or regulator dropped");
	stat_refuse_a: assert property (debug_status_access_i && lite && $stable(mode_o) |->
		##[1:2] debug_status_error_o) else $error("status access not refused");
	bg_all_a: assert property (mode_o == 2'd3 && $stable(mode_o) |-> debug_all_cmds_o)
		else $error("background mode refuses commands");
	pin_hold_a: assert property (deep && $stable(mode_o) |->
		$stable(pin_out_o) && $stable(pin_oe_o)) else $error("pins moved in deep stop");
	deep_por_a: assert property ($past(mode_o) == 2'd2 && mode_o == 2'd0 |->
		##[0:3] por_reset_o) else $error("no power-on pulse after deep wake");
endmodule : stop_mode_power_control_chk
`default_nettype wire

/* stop_mode_power_control_tb.sv */
// self-checking bench for the stop mode power controller
`timescale 1ns/1ps
`default_nettype none
module stop_mode_power_control_tb;
	localparam logic [7:0] CT = stop_ctrl_pkg::CTRL_OFS;
	localparam logic [7:0] ST = stop_ctrl_pkg::STATUS_OFS;
	localparam logic [7:0] CG = stop_ctrl_pkg::CLKGEN_OFS;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, fire = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic ack_o, stop_exec_i, debug_background_cmd_i, debug_status_access_i, e, g;
	logic debug_status_error_o, debug_status_grant_o, debug_all_cmds_o, por_reset_o;
	logic debug_mode_enable_i = 1'b0, reset_pin_n_i = 1'b1, rtc_event_i = 1'b0;
	logic shared_interrupt_pin_n_i = 1'b1;
	logic [1:0] kind = 2'd0, mode_o;
	logic [7:0] port_out_i = 8'h00, port_dir_i = 8'h00, periph_en_i = 8'h00;
	logic [7:0] periph_out_i = 8'h00, periph_dir_i = 8'h00, pin_out_o, pin_oe_o;
	stop_ctrl_pkg::power_ctl_t power_ctl_o;
	int err_count = 0, n_compared = 0, ticks = 0;
	always #5 clk_i = ~clk_i;
	stop_mode_power_control #(.PIN_COUNT(8), .OLD_SILICON(1'b1)) dut (
		.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.stop_exec_i, .debug_mode_enable_i, .debug_background_cmd_i, .debug_status_access_i,
		.debug_status_error_o, .debug_status_grant_o, .debug_all_cmds_o, .reset_pin_n_i,
		.rtc_event_i, .shared_interrupt_pin_n_i, .port_out_i, .port_dir_i, .periph_en_i,
		.periph_out_i, .periph_dir_i, .pin_out_o, .pin_oe_o, .power_ctl_o, .por_reset_o,
		.mode_o);
	core_model core (.fire_i(fire), .kind_i(kind), .stop_o(stop_exec_i),
		.bg_o(debug_background_cmd_i), .acc_o(debug_status_access_i));
	task tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	// a hang costs a mismatch; the whole run needs well under this
	always @(posedge clk_i)
	begin
		ticks++;
		if (ticks == 4000)
		begin
			err_count++;
			tally_and_finish();
		end
	end
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	// classic cycle; the answer is read at the edge that samples ack
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'h1, 24'h0, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1);
		rd = dat_o;
		{cyc_i, stb_i} <= 2'b00;
		chk("ack wait", n, 32'h2);
	endtask : wb
	task pulse(input logic [1:0] k);
		@(posedge clk_i);
		kind <= k;
		fire <= 1'b1;
		@(posedge clk_i);
		fire <= 1'b0;
	endtask : pulse
	task access();
		{e, g} = 2'b00;
		pulse(2'd2);
		repeat (3)
		begin
			@(posedge clk_i);
			{e, g} = {e | debug_status_error_o, g | debug_status_grant_o};
		end
	endtask : access
	task go_stop(input logic [7:0] c, input logic [1:0] m, input logic [9:0] p);
		wb(1'b1, CT, c);
		pulse(2'd0);
		tick(4);
		chk("mode", mode_o, m);
		chk("power", power_ctl_o, p);
	endtask : go_stop
	// wake source held four cycles: 0 counter, 1 interrupt pin, 2 reset pin
	task wake(input int s, input logic por);
		logic p;
		p = 1'b0;
		@(posedge clk_i);
		{rtc_event_i, shared_interrupt_pin_n_i, reset_pin_n_i} <= {s == 0, s != 1, s != 2};
		tick(4);
		{rtc_event_i, shared_interrupt_pin_n_i, reset_pin_n_i} <= 3'b011;
		repeat (10)
		begin
			@(posedge clk_i);
			p |= por_reset_o;
		end
		chk("mode", mode_o, 2'd0);
		chk("por", p, por);
	endtask : wake
	task t_debug();
		debug_mode_enable_i <= 1'b1;
		go_stop(8'h03, 2'd1, 10'h301);
		access();
		chk("refused", {e, g}, 2'b10);
		pulse(2'd1);
		tick(4);
		chk("mode", mode_o, 2'd3);
		access();
		chk("granted", {g, debug_all_cmds_o}, 2'b11);
		rst_i <= 1'b1;
		debug_mode_enable_i <= 1'b0;
		tick(4);
		rst_i <= 1'b0;
		$display("debug test done");
	endtask : t_debug
	task t_light();
		wb(1'b1, CG, 8'h1f);
		go_stop(8'h3f, 2'd1, 10'h13d);
		wake(0, 1'b0);
		chk("power", power_ctl_o, 10'h3ff);
		go_stop(8'h15, 2'd1, 10'h015);
		wake(0, 1'b0);
		wb(1'b1, CG, 8'h05);
		go_stop(8'h11, 2'd1, 10'h005);
		wake(0, 1'b0);
		wb(1'b0, CT, 8'h00);
		chk("ctrl", rd, 32'h11);
		$display("light test done");
	endtask : t_light
	task t_deep();
		{port_out_i, port_dir_i} <= 16'ha5ff;
		go_stop(8'h13, 2'd2, 10'h004);
		port_out_i <= 8'h3c;
		tick(3);
		chk("pins", pin_out_o, 8'ha5);
		wake(0, 1'b1);
		chk("pins", pin_out_o, 8'ha5);
		wb(1'b0, CT, 8'h00);
		chk("ctrl", rd, 32'h0);
		wb(1'b0, ST, 8'h00);
		chk("status", rd, 32'h0c);
		{periph_en_i, periph_out_i, periph_dir_i} <= 24'h0f0906;
		wb(1'b1, CT, 8'h80);
		tick(3);
		chk("pins", {pin_out_o, pin_oe_o}, 16'h39f6);
		wb(1'b0, ST, 8'h00);
		chk("status", rd, 32'h0);
		for (int s = 1; s < 3; s++)
		begin
			go_stop(8'h43, 2'd2, 10'h000);
			wake(s, 1'b1);
			wb(1'b1, CT, 8'h80);
		end
		$display("deep test done");
	endtask : t_deep
	initial
	begin
		tick(4);
		rst_i <= 1'b0;
		chk("power", power_ctl_o, 10'h3ff);
		wb(1'b0, CG, 8'h00);
		chk("clkgen", rd, 32'h0);
		wb(1'b1, 8'h0c, 8'hff);
		wb(1'b0, 8'h0c, 8'h00);
		chk("unmapped", rd, 32'h0);
		$display("reset test done");
		t_debug();
		t_light();
		t_deep();
		tally_and_finish();
	end
endmodule : stop_mode_power_control_tb
bind stop_mode_power_control stop_mode_power_control_chk #(.PIN_COUNT(PIN_COUNT)) chk (
	.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .debug_mode_enable_i, .debug_status_access_i,
	.debug_status_error_o, .debug_all_cmds_o, .pin_out_o, .pin_oe_o, .power_ctl_o,
	.por_reset_o, .mode_o);
`default_nettype wire
